// File: verilog/srs_pkg.sv
// Constants, register map and carrier types of the status reporting block
// Summary of operation
// - Request-service bit raises the bus service request
// - Request bit cleared by poll or event read
// - Serial poll returns byte, clears only bit 6
// - Status query: in order, clears nothing
// - Message-available set until output buffer drained
// - Operation-complete command sets event bit 0
// - Operation-complete query queues the value one
// - Output buffer overload halts command processing
// - Twenty-entry error queue, oldest first, indicator
// - Condition reads 0 off, 1, 2, 3 failure
// - Questionable events latch, clear when read
// - Questionable enable mask gates questionable summary
// - Clear-status clears event registers, error queue and byte except MAV
// - Standard event enable mask gates event summary
// - Standard event read returns binary-weighted bits
// - Power-on-clear setting decides service and event enable masks at power-up
// - Wait command holds later commands until done
// - Enable bit 5 requests service on events
// - Byte bits 3, 4, 5, 6; others zero
// - Summary bits unlatched, follow their event registers; MAV follows the output buffer
// - Questionable bits 0, 1, 4, 9 only
package srs_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] SRS_OFF_SPOLL = 8'h00;
  localparam logic [7:0] SRS_OFF_STB = 8'h04;
  localparam logic [7:0] SRS_OFF_SRE = 8'h08;
  localparam logic [7:0] SRS_OFF_ESR = 8'h0C;
  localparam logic [7:0] SRS_OFF_ESE = 8'h10;
  localparam logic [7:0] SRS_OFF_QCOND = 8'h14;
  localparam logic [7:0] SRS_OFF_QEVENT = 8'h18;
  localparam logic [7:0] SRS_OFF_QENABLE = 8'h1C;
  localparam logic [7:0] SRS_OFF_CMD = 8'h20;
  localparam logic [7:0] SRS_OFF_PSC = 8'h24;
  localparam logic [7:0] SRS_OFF_OUTBUF = 8'h28;
  localparam logic [7:0] SRS_OFF_ERRQ = 8'h2C;
  localparam logic [7:0] SRS_OFF_STATUS = 8'h30;

  // Status byte bit positions
  localparam int SRS_STB_QUES = 3;
  localparam int SRS_STB_MAV = 4;
  localparam int SRS_STB_ESB = 5;
  localparam int SRS_STB_RQS = 6;
  localparam logic [7:0] SRS_SRE_WMASK = 8'hBF;

  // Standard event register
  localparam int SRS_ESR_OPC = 0;
  localparam int SRS_ESR_PON = 7;
  localparam logic [7:0] SRS_ESR_MASK = 8'hBD;

  // Questionable register
  localparam int SRS_QUES_CURR_REG = 0;
  localparam int SRS_QUES_VOLT_MODE = 1;
  localparam int SRS_QUES_FAN = 4;
  localparam int SRS_QUES_OV = 9;

  // Command register bits
  localparam int SRS_CMD_CLS = 0;
  localparam int SRS_CMD_OPC = 1;
  localparam int SRS_CMD_OPCQ = 2;
  localparam int SRS_CMD_WAI = 3;

  // Block status register bits
  localparam int SRS_ST_HALT = 0;
  localparam int SRS_ST_ERR = 1;
  localparam int SRS_ST_WAIT = 2;

  // Reset values and fixed data
  localparam logic SRS_PSC_RST = 1'b1;
  localparam logic [7:0] SRS_OPCQ_REPLY = 8'h01;
  localparam logic [15:0] SRS_ERR_OVF = 16'hFEA2;
  localparam int SRS_ERR_DEPTH = 20;
  localparam int SRS_OUT_DEPTH = 8;

  typedef struct packed {
    logic ov_trip;
    logic fan_fault;
    logic constant_voltage_mode;
    logic constant_current_regulation;
  } srs_qin_t;

endpackage

// File: verilog/srs_err_queue.sv
// Error queue, oldest entry first, with overflow marker
`timescale 1ns/1ps
module srs_err_queue #(
  parameter int DEPTH = 20,
  parameter int W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] code,
  input wire logic pop,
  // Status
  output logic [W-1:0] head,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic ovf_q;
  logic full, do_pop, do_push, ovf_hit;

  if (DEPTH < 2) begin : g_chk
    $error("srs_err_queue: DEPTH must be at least 2");
  end

  function automatic logic [AW-1:0] wrap(input logic [AW:0] i);
    return (i >= DEPTH_C) ? AW'(i - DEPTH_C) : i[AW-1:0];
  endfunction

  assign full = (cnt_q == DEPTH_C);
  assign empty = (cnt_q == '0);
  assign do_pop = pop & ~empty;
  assign do_push = push & ~ovf_q & (~full | do_pop);
  // Once full, the youngest entry becomes the overflow marker
  assign ovf_hit = push & full & ~do_pop & ~ovf_q;
  assign head = empty ? '0 : mem[rd_q];

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wrap({1'b0, rd_q} + cnt_q)] <= code;
    end else if (ovf_hit) begin
      mem[wrap({1'b0, rd_q} + cnt_q - 1'b1)] <= W'(srs_pkg::SRS_ERR_OVF);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else if (clr) begin
      rd_q <= '0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (do_pop) begin
        rd_q <= wrap({1'b0, rd_q} + 1'b1);
      end
      cnt_q <= cnt_q + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
      if (do_pop) begin
        ovf_q <= 1'b0;
      end else if (ovf_hit) begin
        ovf_q <= 1'b1;
      end
    end
  end
endmodule

// File: verilog/srs_out_queue.sv
// Output message buffer holding queued query replies
`timescale 1ns/1ps
module srs_out_queue #(
  parameter int DEPTH = 8,
  parameter int W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic push,
  input wire logic [W-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [W-1:0] head,
  // Status
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] rd_q, wr_q;
  logic [AW:0] cnt_q;
  logic do_push, do_pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("srs_out_queue: DEPTH must be a power of two, at least 2");
  end

  assign empty = (cnt_q == '0);
  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign do_pop = pop & ~empty;
  // A push into a full buffer with no pop in the same cycle is lost; the owner flags the overload
  assign do_push = push & (~full | do_pop);
  assign head = empty ? '0 : mem[rd_q];

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_q] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
    end
  end
endmodule

// File: verilog/srs_status_core.sv
// Status byte, event registers, service request and queues behind APB
`timescale 1ns/1ps
module srs_status_core #(
  parameter int ADDR_W = 8,
  parameter int ERR_DEPTH = srs_pkg::SRS_ERR_DEPTH,
  parameter int OUT_DEPTH = srs_pkg::SRS_OUT_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instrument events
  input wire logic power_on,
  input wire logic ops_pending,
  input wire logic [7:0] std_evt,
  input wire srs_pkg::srs_qin_t qin,
  // Query replies from the instrument
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  output logic resp_ready,
  // Error reports
  input wire logic err_push,
  input wire logic [15:0] err_code,
  // Bus and front panel
  output logic srq,
  output logic err_any,
  output logic halted
);
  logic [7:0] sre_q, ese_q, esr_q, esr_d, stb;
  logic [15:0] qen_q, qev_q, qev_d, qev_set, qcond;
  logic psc_q, rqs_q, req_prev_q, halt_q, wai_q;
  logic [31:0] prdata_q, rd_mux;
  logic err_vld_q, out_vld_q;
  logic esb, ques, mav, req_cond, req_rise, req_no_esb, req_no_ques;
  logic unmapped, cmd_class, stall, done, wr_done, rd_done;
  logic cls, opc, opcq, wai, spoll_rd, stb_rd, esr_rd, qev_rd;
  logic out_rd, err_rd, out_empty, out_full, out_push, out_pop;
  logic [7:0] out_head, out_data;
  logic [15:0] err_head;
  logic err_empty;

  if (ADDR_W < 6) begin : g_chk
    $error("srs_status_core: ADDR_W too small for the register map");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  // ESB and QUES are unlatched views of event AND enable; MAV shows a non-empty output buffer
  assign esb = |(esr_q & ese_q);
  assign ques = |(qev_q & qen_q);
  assign mav = ~out_empty;

  always_comb begin
    stb = 8'h00;
    stb[srs_pkg::SRS_STB_QUES] = ques;
    stb[srs_pkg::SRS_STB_MAV] = mav;
    stb[srs_pkg::SRS_STB_ESB] = esb;
    stb[srs_pkg::SRS_STB_RQS] = rqs_q;
  end

  // Request condition never includes bit 6 itself
  assign req_cond = |(stb & srs_pkg::SRS_SRE_WMASK & sre_q);
  assign req_no_esb = |({2'b00, 1'b0, mav, ques, 3'b000} & sre_q);
  assign req_no_ques = |({2'b00, esb, mav, 1'b0, 3'b000} & sre_q);
  assign req_rise = req_cond & ~req_prev_q;

  // Condition register: current regulation bit 0, voltage mode bit 1
  always_comb begin
    qcond = 16'h0000;
    qcond[srs_pkg::SRS_QUES_CURR_REG] = qin.constant_current_regulation;
    qcond[srs_pkg::SRS_QUES_VOLT_MODE] = qin.constant_voltage_mode;
  end

  always_comb begin
    qev_set = qcond;
    qev_set[srs_pkg::SRS_QUES_FAN] = qin.fan_fault;
    qev_set[srs_pkg::SRS_QUES_OV] = qin.ov_trip;
  end

  // Register decode and read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unmapped = 1'b0;
    cmd_class = 1'b1;
    if (hit(paddr, srs_pkg::SRS_OFF_SPOLL)) begin
      rd_mux[7:0] = stb;
      cmd_class = 1'b0;
    end else if (hit(paddr, srs_pkg::SRS_OFF_STB)) begin
      rd_mux[7:0] = stb;
    end else if (hit(paddr, srs_pkg::SRS_OFF_SRE)) begin
      rd_mux[7:0] = sre_q;
    end else if (hit(paddr, srs_pkg::SRS_OFF_ESR)) begin
      rd_mux[7:0] = esr_q;
    end else if (hit(paddr, srs_pkg::SRS_OFF_ESE)) begin
      rd_mux[7:0] = ese_q;
    end else if (hit(paddr, srs_pkg::SRS_OFF_QCOND)) begin
      rd_mux[15:0] = qcond;
    end else if (hit(paddr, srs_pkg::SRS_OFF_QEVENT)) begin
      rd_mux[15:0] = qev_q;
    end else if (hit(paddr, srs_pkg::SRS_OFF_QENABLE)) begin
      rd_mux[15:0] = qen_q;
    end else if (hit(paddr, srs_pkg::SRS_OFF_CMD)) begin
      rd_mux = 32'h0000_0000;
    end else if (hit(paddr, srs_pkg::SRS_OFF_PSC)) begin
      rd_mux[0] = psc_q;
    end else if (hit(paddr, srs_pkg::SRS_OFF_OUTBUF)) begin
      rd_mux[7:0] = out_head;
      cmd_class = 1'b0;
    end else if (hit(paddr, srs_pkg::SRS_OFF_ERRQ)) begin
      rd_mux[15:0] = err_head;
    end else if (hit(paddr, srs_pkg::SRS_OFF_STATUS)) begin
      rd_mux[srs_pkg::SRS_ST_HALT] = halt_q;
      rd_mux[srs_pkg::SRS_ST_ERR] = ~err_empty;
      rd_mux[srs_pkg::SRS_ST_WAIT] = wai_q;
      cmd_class = 1'b0;
    end else begin
      unmapped = 1'b1;
      cmd_class = 1'b0;
    end
  end

  // Commands and in-order queries stall; poll and drain never do
  assign stall = cmd_class & (halt_q | (wai_q & ops_pending));
  assign pready = ~(psel & stall);
  assign done = psel & penable & pready;
  assign pslverr = done & unmapped;
  assign prdata = prdata_q;
  assign wr_done = done & pwrite & ~unmapped;
  assign rd_done = done & ~pwrite & ~unmapped;

  assign spoll_rd = rd_done & hit(paddr, srs_pkg::SRS_OFF_SPOLL);
  assign stb_rd = rd_done & hit(paddr, srs_pkg::SRS_OFF_STB);
  assign esr_rd = rd_done & hit(paddr, srs_pkg::SRS_OFF_ESR);
  assign qev_rd = rd_done & hit(paddr, srs_pkg::SRS_OFF_QEVENT);
  assign out_rd = rd_done & hit(paddr, srs_pkg::SRS_OFF_OUTBUF);
  assign err_rd = rd_done & hit(paddr, srs_pkg::SRS_OFF_ERRQ);

  assign cls = wr_done & hit(paddr, srs_pkg::SRS_OFF_CMD) &
               pwdata[srs_pkg::SRS_CMD_CLS];
  assign opc = wr_done & hit(paddr, srs_pkg::SRS_OFF_CMD) &
               pwdata[srs_pkg::SRS_CMD_OPC];
  assign opcq = wr_done & hit(paddr, srs_pkg::SRS_OFF_CMD) &
                pwdata[srs_pkg::SRS_CMD_OPCQ];
  assign wai = wr_done & hit(paddr, srs_pkg::SRS_OFF_CMD) &
               pwdata[srs_pkg::SRS_CMD_WAI];

  // Read data is sampled a cycle early; clears use exactly what was shown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_vld_q <= 1'b0;
      out_vld_q <= 1'b0;
    end else if (psel) begin
      prdata_q <= rd_mux;
      err_vld_q <= ~err_empty;
      out_vld_q <= ~out_empty;
    end
  end

  // Enable masks and power-on-clear setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sre_q <= 8'h00;
      ese_q <= 8'h00;
      qen_q <= 16'h0000;
      psc_q <= srs_pkg::SRS_PSC_RST;
    end else begin
      if (power_on && psc_q) begin
        sre_q <= 8'h00;
        ese_q <= 8'h00;
      end else begin
        if (wr_done && hit(paddr, srs_pkg::SRS_OFF_SRE)) begin
          sre_q <= pwdata[7:0] & srs_pkg::SRS_SRE_WMASK;
        end
        if (wr_done && hit(paddr, srs_pkg::SRS_OFF_ESE)) begin
          ese_q <= pwdata[7:0];
        end
      end
      if (wr_done && hit(paddr, srs_pkg::SRS_OFF_QENABLE)) begin
        qen_q <= pwdata[15:0];
      end
      if (wr_done && hit(paddr, srs_pkg::SRS_OFF_PSC)) begin
        psc_q <= pwdata[0];
      end
    end
  end

  // Standard event register: new events win over any clear
  always_comb begin
    esr_d = esr_q;
    if (cls || power_on) begin
      esr_d = 8'h00;
    end else if (esr_rd) begin
      esr_d = esr_q & ~prdata_q[7:0];
    end
    esr_d = esr_d | (std_evt & srs_pkg::SRS_ESR_MASK);
    esr_d[srs_pkg::SRS_ESR_OPC] = esr_d[srs_pkg::SRS_ESR_OPC] | opc;
    esr_d[srs_pkg::SRS_ESR_PON] = esr_d[srs_pkg::SRS_ESR_PON] | power_on;
  end

  // Questionable events latch from levels, clear on read or clear-status
  always_comb begin
    qev_d = qev_q;
    if (cls || power_on) begin
      qev_d = 16'h0000;
    end else if (qev_rd) begin
      qev_d = qev_q & ~prdata_q[15:0];
    end
    qev_d = qev_d | qev_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esr_q <= 8'h00;
      qev_q <= 16'h0000;
    end else begin
      esr_q <= esr_d;
      qev_q <= qev_d;
    end
  end

  // Request-service bit: set on a new request, cleared only as allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rqs_q <= 1'b0;
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= req_cond;
      if (req_rise) begin
        rqs_q <= 1'b1;
      end else if (spoll_rd || cls) begin
        rqs_q <= 1'b0;
      end else if ((esr_rd && req_no_esb) || (qev_rd && req_no_ques)) begin
        rqs_q <= rqs_q;
      end else if (esr_rd || qev_rd) begin
        rqs_q <= 1'b0;
      end
    end
  end

  assign srq = rqs_q;

  // Wait holds later commands while operations are pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wai_q <= 1'b0;
    end else if (wai) begin
      wai_q <= 1'b1;
    end else if (!ops_pending) begin
      wai_q <= 1'b0;
    end
  end

  // Output buffer: completion-query reply has priority over replies
  assign out_push = opcq | (resp_valid & resp_ready);
  assign out_data = opcq ? srs_pkg::SRS_OPCQ_REPLY : resp_data;
  assign resp_ready = ~halt_q & ~opcq;
  assign out_pop = out_rd & out_vld_q;

  // Overload stops command processing until software drains a reply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= 1'b0;
    end else if (out_push && out_full && !out_pop) begin
      halt_q <= 1'b1;
    end else if (out_pop) begin
      halt_q <= 1'b0;
    end
  end

  assign halted = halt_q;
  assign err_any = ~err_empty;

  srs_out_queue #(
    .DEPTH(OUT_DEPTH),
    .W(8)
  ) u_out (
    .pclk(pclk),
    .presetn(presetn),
    .push(out_push),
    .push_data(out_data),
    .pop(out_pop),
    .head(out_head),
    .empty(out_empty),
    .full(out_full)
  );

  srs_err_queue #(
    .DEPTH(ERR_DEPTH),
    .W(16)
  ) u_err (
    .pclk(pclk),
    .presetn(presetn),
    .clr(cls | power_on),
    .push(err_push),
    .code(err_code),
    .pop(err_rd & err_vld_q),
    .head(err_head),
    .empty(err_empty)
  );

  property p_rqs_raise;
    @(posedge pclk) disable iff (!presetn)
      req_rise |=> srq ##0 stb[srs_pkg::SRS_STB_RQS];
  endproperty
  a_rqs_raise: assert property (p_rqs_raise)
    else $error("service request not raised");

  property p_spoll_clear;
    @(posedge pclk) disable iff (!presetn)
      spoll_rd && !req_rise |=> !srq;
  endproperty
  a_spoll_clear: assert property (p_spoll_clear)
    else $error("serial poll left request bit set");

  property p_stb_keep;
    @(posedge pclk) disable iff (!presetn)
      stb_rd && srq && !cls |=> srq;
  endproperty
  a_stb_keep: assert property (p_stb_keep)
    else $error("status query cleared request bit");

  property p_opc_set;
    @(posedge pclk) disable iff (!presetn)
      opc && !power_on |=> esr_q[srs_pkg::SRS_ESR_OPC];
  endproperty
  a_opc_set: assert property (p_opc_set)
    else $error("operation complete bit not set");

  property p_opcq_mav;
    @(posedge pclk) disable iff (!presetn)
      opcq && !out_full |=> stb[srs_pkg::SRS_STB_MAV];
  endproperty
  a_opcq_mav: assert property (p_opcq_mav)
    else $error("completion reply not queued");

  property p_overload;
    @(posedge pclk) disable iff (!presetn)
      out_push && out_full && !out_pop |=>
        halted ##1 (halted || $past(out_pop));
  endproperty
  a_overload: assert property (p_overload)
    else $error("overload did not halt commands");

  property p_wai_hold;
    @(posedge pclk) disable iff (!presetn)
      wai_q && ops_pending && psel && cmd_class |-> !pready;
  endproperty
  a_wai_hold: assert property (p_wai_hold)
    else $error("command ran during wait");

  property p_qev_latch;
    @(posedge pclk) disable iff (!presetn)
      $rose(qin.fan_fault) |=> qev_q[srs_pkg::SRS_QUES_FAN] [*2];
  endproperty
  a_qev_latch: assert property (p_qev_latch)
    else $error("questionable event not latched");

  property p_cls;
    @(posedge pclk) disable iff (!presetn)
      cls && std_evt == 8'h00 && !opc |=> esr_q == 8'h00 && !srq;
  endproperty
  a_cls: assert property (p_cls)
    else $error("clear status left events");

  property p_psc;
    @(posedge pclk) disable iff (!presetn)
      power_on && psc_q |=> sre_q == 8'h00 && ese_q == 8'h00;
  endproperty
  a_psc: assert property (p_psc)
    else $error("power-on clear did not clear masks");

  c_poll_after_srq: cover property (@(posedge pclk) disable iff (!presetn)
    srq ##[1:20] spoll_rd);
  c_overload: cover property (@(posedge pclk) disable iff (!presetn)
    halted ##[1:50] out_pop);
  c_err_drain: cover property (@(posedge pclk) disable iff (!presetn)
    err_any ##[1:100] !err_any);
endmodule

// File: verif/srs_host_model.sv
// Bus controller model issuing one APB transfer per request
`timescale 1ns/1ps
module srs_host_model (
  // Clock
  input wire logic pclk,
  // Bench side
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic err,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    done = 1'b1;
    rdata = 32'h0;
    err = 1'b0;
  end
  always @(posedge pclk) begin
    if (!psel && go) begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      done <= 1'b0;
    end else if (psel && !penable) begin
      penable <= 1'b1;
    end else if (psel && pready) begin
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so a stale value is never mistaken for data
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      rdata <= prdata;
      err <= pslverr;
      done <= 1'b1;
    end
  end
endmodule

// File: verif/tb_status_reporting_service_request.sv
// Self-checking bench of the status reporting core
`timescale 1ns/1ps
module tb_status_reporting_service_request;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic power_on = 1'b0;
  logic ops_pending = 1'b0;
  logic resp_valid = 1'b0;
  logic err_push = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] std_evt = 8'h00;
  logic [7:0] resp_data = 8'h00;
  logic [15:0] err_code = 16'h0000;
  logic [31:0] wdata = 32'h0;
  srs_pkg::srs_qin_t qin = '0;
  logic done, err, psel, penable, pwrite, pready, pslverr;
  logic resp_ready, srq, err_any, halted;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int miscompares = 0;
  int tests_run = 0;

  always #2.5 pclk = ~pclk;

  srs_status_core i_srs_status_core (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_on,
    .ops_pending, .std_evt, .qin, .resp_valid, .resp_data, .resp_ready,
    .err_push, .err_code, .srq, .err_any, .halted);
  srs_host_model i_srs_host_model (.pclk, .go, .wr, .addr, .wdata, .done,
    .rdata, .err, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic start(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  task automatic finish();
    int n;
    n = 0;
    @(posedge pclk);
    while (done !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n == 300) chk("bus wait", 32'h1, 32'h0);
  endtask
  task automatic wrr(logic [7:0] a, logic [31:0] d);
    start(1'b1, a, d);
    finish();
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] e);
    start(1'b0, a, 32'h0);
    finish();
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic evt(logic [7:0] v);
    @(posedge pclk) std_evt <= v;
    @(posedge pclk) std_evt <= 8'h00;
  endtask
  task automatic pon();
    @(posedge pclk) power_on <= 1'b1;
    @(posedge pclk) power_on <= 1'b0;
  endtask

  task automatic t_reset();
    rc(8'h24, 32'h1);
    rc(8'h04, 32'h0);
    chk("srq", 32'h0, 32'(srq));
  endtask
  task automatic t_masks();
    wrr(8'h08, 32'hFF);
    rc(8'h08, 32'hBF);
    wrr(8'h10, 32'hBD);
    rc(8'h10, 32'hBD);
    wrr(8'h1C, 32'h213);
    rc(8'h1C, 32'h213);
    wrr(8'h1C, 32'h0);
  endtask
  task automatic t_opc();
    wrr(8'h20, 32'h1);
    wrr(8'h10, 32'h1);
    wrr(8'h08, 32'h20);
    wrr(8'h20, 32'h4);
    rc(8'h28, 32'h1);
    wrr(8'h20, 32'h2);
    evt(8'h10);
    rc(8'h04, 32'h60);
    chk("srq", 32'h1, 32'(srq));
    rc(8'h04, 32'h60);
    rc(8'h00, 32'h60);
    chk("srq", 32'h0, 32'(srq));
    rc(8'h04, 32'h20);
    rc(8'h0C, 32'h11);
    rc(8'h04, 32'h0);
  endtask
  task automatic t_ques();
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk) qin <= 4'(i);
      rc(8'h14, 32'(i));
    end
    @(posedge pclk) qin <= '0;
    rc(8'h18, 32'h3);
    rc(8'h18, 32'h0);
    wrr(8'h1C, 32'h200);
    wrr(8'h08, 32'h08);
    @(posedge pclk) qin <= 4'hC;
    @(posedge pclk) qin <= '0;
    rc(8'h04, 32'h48);
    chk("srq", 32'h1, 32'(srq));
    rc(8'h18, 32'h210);
    chk("srq", 32'h0, 32'(srq));
    rc(8'h04, 32'h0);
  endtask
  task automatic t_mav();
    wrr(8'h20, 32'h4);
    wrr(8'h20, 32'h4);
    rc(8'h04, 32'h10);
    rc(8'h28, 32'h1);
    rc(8'h04, 32'h10);
    rc(8'h28, 32'h1);
    rc(8'h04, 32'h0);
  endtask
  task automatic t_ovl();
    // Nine replies against an eight-deep buffer
    for (int i = 0; i < 9; i++) begin
      @(posedge pclk) begin
        resp_valid <= 1'b1;
        resp_data <= 8'(i);
      end
    end
    @(posedge pclk) resp_valid <= 1'b0;
    @(posedge pclk);
    chk("halted", 32'h1, 32'(halted));
    chk("resp_ready", 32'h0, 32'(resp_ready));
    rc(8'h30, 32'h1);
    for (int i = 0; i < 8; i++) rc(8'h28, 32'(i));
    chk("halted", 32'h0, 32'(halted));
    rc(8'h04, 32'h0);
  endtask
  task automatic t_errq();
    for (int i = 1; i < 22; i++) begin
      @(posedge pclk) begin
        err_push <= 1'b1;
        err_code <= 16'(i);
      end
    end
    @(posedge pclk) err_push <= 1'b0;
    @(posedge pclk);
    chk("err_any", 32'h1, 32'(err_any));
    for (int i = 1; i < 20; i++) rc(8'h2C, 32'(i));
    rc(8'h2C, 32'hFEA2);
    chk("err_any", 32'h0, 32'(err_any));
    rc(8'h2C, 32'h0);
  endtask
  task automatic t_cls();
    evt(8'hBD);
    wrr(8'h20, 32'h1);
    rc(8'h0C, 32'h0);
    rc(8'h04, 32'h0);
  endtask
  task automatic t_pon();
    wrr(8'h24, 32'h0);
    wrr(8'h08, 32'h20);
    wrr(8'h10, 32'h1);
    pon();
    rc(8'h08, 32'h20);
    rc(8'h10, 32'h1);
    rc(8'h0C, 32'h80);
    wrr(8'h24, 32'h1);
    pon();
    rc(8'h08, 32'h0);
    rc(8'h10, 32'h0);
    rc(8'h24, 32'h1);
  endtask
  task automatic t_wai();
    @(posedge pclk) ops_pending <= 1'b1;
    wrr(8'h20, 32'h8);
    start(1'b0, 8'h04, 32'h0);
    repeat (10) @(posedge pclk);
    chk("held", 32'h0, 32'(done));
    ops_pending <= 1'b0;
    finish();
    chk("stb", 32'h0, rdata);
    start(1'b0, 8'h3C, 32'h0);
    finish();
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rdata);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_masks();
    t_opc();
    t_ques();
    t_mav();
    t_ovl();
    t_errq();
    t_cls();
    t_pon();
    t_wai();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
endmodule
